//--- verilog/irq_timer_pkg.sv
// Shared constants and types for the interrupt and timer 0/1 control block
package irq_timer_pkg;
    // ----------------------------------------
    // Register indices (byte address = 4 x index)
    // ----------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_TCTL = 8'h88;
    localparam logic [7:0] IDX_TMODE = 8'h89;
    localparam logic [7:0] IDX_TL0 = 8'h8A;
    localparam logic [7:0] IDX_TL1 = 8'h8B;
    localparam logic [7:0] IDX_TH0 = 8'h8C;
    localparam logic [7:0] IDX_TH1 = 8'h8D;
    localparam logic [7:0] IDX_ENA = 8'hA8;
    localparam logic [7:0] IDX_PRI = 8'hB8;
    localparam logic [7:0] IDX_XCTL = 8'hC0;
    localparam logic [7:0] RST_REG = 8'h00;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int B_T1_OVF = 7;
    localparam int B_T1_RUN = 6;
    localparam int B_T0_OVF = 5;
    localparam int B_T0_RUN = 4;
    localparam int B_X1_FLAG = 3;
    localparam int B_X1_TYPE = 2;
    localparam int B_X0_FLAG = 1;
    localparam int B_X0_TYPE = 0;
    localparam int B_GLOBAL = 7;
    localparam int B_X3_PRI = 7;
    localparam int B_X3_ENA = 6;
    localparam int B_X3_FLAG = 5;
    localparam int B_X3_TYPE = 4;
    localparam int B_X2_PRI = 3;
    localparam int B_X2_ENA = 2;
    localparam int B_X2_FLAG = 1;
    localparam int B_X2_TYPE = 0;
    // ----------------------------------------
    // Sources, vectors, modes, timing
    // ----------------------------------------
    localparam int N_SRC = 8;
    localparam logic [2:0] SRC_X0 = 3'h0;
    localparam logic [2:0] SRC_T0 = 3'h1;
    localparam logic [2:0] SRC_X1 = 3'h2;
    localparam logic [2:0] SRC_T1 = 3'h3;
    localparam logic [2:0] SRC_X2 = 3'h6;
    localparam logic [2:0] SRC_X3 = 3'h7;
    localparam logic [7:0] VEC_BASE = 8'h03;
    localparam logic [7:0] VEC_LAST = 8'h3B;
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam int TICK_DIV_DEF = 12;
    typedef struct packed {
        logic gate;
        logic counter;
        logic [1:0] mode;
    } tmode_s;
    typedef enum logic {ARB, OFFER} offer_e;
endpackage : irq_timer_pkg

//--- verilog/irq_timer_ctl.sv
// Interrupt controller with timer 0/1 run and mode control, Avalon-MM slave
// Function
// [RULE1] Eight fixed vectors 03H to 3BH; lower index wins within a level.
// [RULE2] Global enable bit gates every source.
// [RULE3] Enable register bits 0-5: ext0, timer0, ext1, timer1, serial, timer2.
// [RULE4] Priority register: one high-priority bit per standard source.
// [RULE5] Extra register holds enable and high-priority bits for ext2, ext3.
// [RULE6] Ext2/ext3 type bit: set falling edge, clear low level.
// [RULE7] Ext2/ext3 edge flag set on falling edge, cleared on service.
// [RULE8] Ext0/ext1 edge flags set on edge, cleared on service.
// [RULE9] Ext0/ext1 type bit: set falling edge, clear low level.
// [RULE10] Timer overflow flags set on overflow, cleared when vectored.
// [RULE11] Run bit starts and stops each timer.
// [RULE12] Gate set: count only while pin high and run set.
// [RULE13] Select bit: clear internal timing, set external event counting.
// [RULE14] Mode 00 is 13-bit, mode 01 is 16-bit.
// [RULE15] Mode 10: 8-bit low byte reloaded from high byte on overflow.
// [RULE16] Timer0 mode 11: low byte own timer, high byte on timer1 controls.
// [RULE17] Timer1 mode 11: timer1 stops and holds.
// [RULE18] Mode register: timer1 upper nibble, timer0 lower nibble.
// [RULE19] High level preempts low service; equal or higher never interrupted.
// [RULE20] Ext2 and ext3 come from the two upper bits of the 4-bit port.
module irq_timer_ctl
    import irq_timer_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire logic [3:0] four_bit_port,
    input wire logic t0_pin,
    input wire logic t1_pin,
    input wire logic serial_irq,
    input wire logic timer2_irq,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic irq_pending,
    output logic [7:0] irq_vector,
    output logic irq_level
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] timer_run_and_flag_control;
    logic [7:0] timer_mode_select;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] interrupt_priority_select;
    logic [7:0] extra_external_irq_control;
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [3:0] ext_prev;
    logic [1:0] tpin_prev;
    logic [7:0] presc;
    logic in_hi;
    logic in_lo;
    logic [2:0] src;
    offer_e state;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire [7:0] idx = address[ADDR_W-1:2];
    wire req = read | write;
    wire wr_en = write & ~waitrequest & byteenable[0];
    wire [7:0] wd = writedata[7:0];
    wire wr_tctl = wr_en & (idx == IDX_TCTL);
    wire wr_tmode = wr_en & (idx == IDX_TMODE);
    wire wr_tl0 = wr_en & (idx == IDX_TL0);
    wire wr_tl1 = wr_en & (idx == IDX_TL1);
    wire wr_th0 = wr_en & (idx == IDX_TH0);
    wire wr_th1 = wr_en & (idx == IDX_TH1);
    wire wr_ena = wr_en & (idx == IDX_ENA);
    wire wr_pri = wr_en & (idx == IDX_PRI);
    wire wr_xctl = wr_en & (idx == IDX_XCTL);
    // Unmapped indices read as zero
    wire [7:0] rd_mux =
        (idx == IDX_TCTL) ? timer_run_and_flag_control :
        (idx == IDX_TMODE) ? timer_mode_select :
        (idx == IDX_TL0) ? timer0_low_byte :
        (idx == IDX_TL1) ? timer1_low_byte :
        (idx == IDX_TH0) ? timer0_high_byte :
        (idx == IDX_TH1) ? timer1_high_byte :
        (idx == IDX_ENA) ? interrupt_enable_mask :
        (idx == IDX_PRI) ? {2'b00, interrupt_priority_select[5:0]} :
        (idx == IDX_XCTL) ? extra_external_irq_control : RST_REG;

    // ----------------------------------------
    // External pins and edge flags
    // ----------------------------------------
    // [RULE20] Upper port bits
    wire [3:0] ext_pin = {four_bit_port[2], four_bit_port[3], ext1_pin, ext0_pin};
    // [RULE6] [RULE9] Trigger type
    wire [3:0] ext_type = {extra_external_irq_control[B_X3_TYPE],
                           extra_external_irq_control[B_X2_TYPE],
                           timer_run_and_flag_control[B_X1_TYPE],
                           timer_run_and_flag_control[B_X0_TYPE]};
    wire [3:0] ext_flag = {extra_external_irq_control[B_X3_FLAG],
                           extra_external_irq_control[B_X2_FLAG],
                           timer_run_and_flag_control[B_X1_FLAG],
                           timer_run_and_flag_control[B_X0_FLAG]};
    wire [3:0] ext_wbit = {wd[B_X3_FLAG], wd[B_X2_FLAG], wd[B_X1_FLAG], wd[B_X0_FLAG]};
    wire [3:0] ext_wsel = {wr_xctl, wr_xctl, wr_tctl, wr_tctl};
    wire [2:0] ext_src [4] = '{SRC_X3, SRC_X2, SRC_X1, SRC_X0};
    wire ack = (state == OFFER) & irq_ack;
    logic [3:0] ext_req;
    logic [3:0] next_ext_flag;
    logic [3:0] ext_set;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ext
            // [RULE7] [RULE8] Edge set wins over clear
            assign ext_set[gi] = ext_type[gi] & ext_prev[gi] & ~ext_pin[gi];
            assign next_ext_flag[gi] = ext_set[gi] |
                (ext_wsel[gi] ? ext_wbit[gi] :
                 (ext_flag[gi] & ~(ack & (src == ext_src[3-gi]))));
            // [RULE6] [RULE9] Level mode requests while pin low
            assign ext_req[gi] = ext_type[gi] ? ext_flag[gi] : ~ext_pin[gi];
        end
    endgenerate

    // ----------------------------------------
    // Timers 0 and 1
    // ----------------------------------------
    // Returns overflow, high byte, low byte after one count
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] th,
                                         input logic [7:0] tl);
        logic [13:0] v13;
        logic [16:0] v16;
        logic [16:0] r;
        v13 = {1'b0, th, tl[4:0]} + 14'h0001;
        v16 = {1'b0, th, tl} + 17'h0_0001;
        r = {1'b0, th, tl};
        case (m)
            // [RULE14] 13 and 16 bit
            MODE_13: r = {v13[13], v13[12:5], tl[7:5], v13[4:0]};
            MODE_16: r = v16;
            // [RULE15] Reload low from high
            MODE_RELOAD: r = {&tl, th, (&tl) ? th : tl + 8'h01};
            MODE_SPLIT: r = {&tl, th, tl + 8'h01};
            default: r = {1'b0, th, tl};
        endcase
        return r;
    endfunction : step

    // [RULE18] Nibble layout
    wire tmode_s tm0 = tmode_s'(timer_mode_select[3:0]);
    wire tmode_s tm1 = tmode_s'(timer_mode_select[7:4]);
    wire tick = (presc == 8'(TICK_DIV - 1));
    wire [1:0] tpin_fall = tpin_prev & ~{t1_pin, t0_pin};
    wire run0_bit = timer_run_and_flag_control[B_T0_RUN];
    wire run1_bit = timer_run_and_flag_control[B_T1_RUN];
    // [RULE11] [RULE12] Run and gate
    wire run0 = run0_bit & (~tm0.gate | ext0_pin);
    wire run1 = run1_bit & (~tm1.gate | ext1_pin);
    wire split = (tm0.mode == MODE_SPLIT);
    // [RULE13] Timer or event count
    wire cnt0 = run0 & (tm0.counter ? tpin_fall[0] : tick);
    // [RULE17] Timer 1 holds in mode 11
    wire cnt1 = run1 & (tm1.counter ? tpin_fall[1] : tick) & (tm1.mode != MODE_SPLIT);
    // [RULE16] High byte of timer 0 on timer 1 run bit
    wire th0_cnt = split & run1_bit & tick;
    wire [16:0] s0 = step(tm0.mode, timer0_high_byte, timer0_low_byte);
    wire [16:0] s1 = step(tm1.mode, timer1_high_byte, timer1_low_byte);
    wire t0_set = cnt0 & s0[16];
    // [RULE16] Split high byte owns the timer 1 flag
    wire t1_set = split ? (th0_cnt & (&timer0_high_byte)) : (cnt1 & s1[16]);
    wire [7:0] next_tl0 = wr_tl0 ? wd : (cnt0 ? s0[7:0] : timer0_low_byte);
    wire [7:0] next_th0 = wr_th0 ? wd :
        (split ? (th0_cnt ? timer0_high_byte + 8'h01 : timer0_high_byte) :
         (cnt0 ? s0[15:8] : timer0_high_byte));
    wire [7:0] next_tl1 = wr_tl1 ? wd : (cnt1 ? s1[7:0] : timer1_low_byte);
    wire [7:0] next_th1 = wr_th1 ? wd : (cnt1 ? s1[15:8] : timer1_high_byte);
    // [RULE10] Overflow set wins over vector clear
    wire next_t0_flag = t0_set | (wr_tctl ? wd[B_T0_OVF] :
        (timer_run_and_flag_control[B_T0_OVF] & ~(ack & (src == SRC_T0))));
    wire next_t1_flag = t1_set | (wr_tctl ? wd[B_T1_OVF] :
        (timer_run_and_flag_control[B_T1_OVF] & ~(ack & (src == SRC_T1))));
    wire [7:0] next_tctl = {next_t1_flag,
        wr_tctl ? wd[B_T1_RUN] : run1_bit,
        next_t0_flag,
        wr_tctl ? wd[B_T0_RUN] : run0_bit,
        next_ext_flag[1],
        wr_tctl ? wd[B_X1_TYPE] : ext_type[1],
        next_ext_flag[0],
        wr_tctl ? wd[B_X0_TYPE] : ext_type[0]};
    wire [7:0] xw = wr_xctl ? wd : extra_external_irq_control;
    wire [7:0] next_xctl = {xw[7:6], next_ext_flag[3], xw[4:2], next_ext_flag[2], xw[0]};

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    wire [7:0] src_req = {ext_req[3], ext_req[2], timer2_irq, serial_irq,
                          timer_run_and_flag_control[B_T1_OVF], ext_req[1],
                          timer_run_and_flag_control[B_T0_OVF], ext_req[0]};
    // [RULE3] [RULE5] Per-source enables
    wire [7:0] src_ena = {extra_external_irq_control[B_X3_ENA],
                          extra_external_irq_control[B_X2_ENA],
                          interrupt_enable_mask[5:0]};
    // [RULE4] [RULE5] Per-source priority
    wire [7:0] src_pri = {extra_external_irq_control[B_X3_PRI],
                          extra_external_irq_control[B_X2_PRI],
                          interrupt_priority_select[5:0]};
    // [RULE2] Global gate
    wire [7:0] live = src_req & src_ena & {N_SRC{interrupt_enable_mask[B_GLOBAL]}};
    wire [7:0] hi = live & src_pri;
    wire [7:0] lo = live & ~src_pri;
    // [RULE19] Nesting by level
    wire take_hi = (|hi) & ~in_hi;
    wire take_lo = (|lo) & ~in_hi & ~in_lo;

    // [RULE1] Lowest index polled first
    function automatic logic [2:0] first(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first

    wire [2:0] pick = take_hi ? first(hi) : first(lo);
    // [RULE1] Vector 03H plus eight per source
    wire [7:0] pick_vec = VEC_BASE + {2'b00, pick, 3'b000};
    wire offer = (state == ARB) & (take_hi | take_lo);
    wire next_in_hi = (ack & irq_level) | (in_hi & ~irq_return);
    wire next_in_lo = (ack & ~irq_level) | (in_lo & ~(irq_return & ~in_hi));

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            waitrequest <= ~(req & waitrequest);
            readdata <= (read & waitrequest) ? {24'h00_0000, rd_mux} : readdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_run_and_flag_control <= RST_REG;
            timer_mode_select <= RST_REG;
            interrupt_enable_mask <= RST_REG;
            interrupt_priority_select <= RST_REG;
            extra_external_irq_control <= RST_REG;
        end else begin
            timer_run_and_flag_control <= next_tctl;
            timer_mode_select <= wr_tmode ? wd : timer_mode_select;
            interrupt_enable_mask <= wr_ena ? {wd[7], 1'b0, wd[5:0]} : interrupt_enable_mask;
            interrupt_priority_select <= wr_pri ? wd : interrupt_priority_select;
            extra_external_irq_control <= next_xctl;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer0_low_byte <= RST_REG;
            timer0_high_byte <= RST_REG;
            timer1_low_byte <= RST_REG;
            timer1_high_byte <= RST_REG;
            presc <= 8'h00;
            ext_prev <= 4'hF;
            tpin_prev <= 2'b11;
        end else begin
            timer0_low_byte <= next_tl0;
            timer0_high_byte <= next_th0;
            timer1_low_byte <= next_tl1;
            timer1_high_byte <= next_th1;
            presc <= tick ? 8'h00 : presc + 8'h01;
            ext_prev <= ext_pin;
            tpin_prev <= {t1_pin, t0_pin};
        end
    end

    // Offer stays up until the core takes it; a later arrival waits its turn
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ARB;
            src <= 3'h0;
            irq_pending <= 1'b0;
            irq_vector <= VEC_BASE;
            irq_level <= 1'b0;
            in_hi <= 1'b0;
            in_lo <= 1'b0;
        end else begin
            in_hi <= next_in_hi;
            in_lo <= next_in_lo;
            case (state)
                ARB: begin
                    if (offer) begin
                        state <= OFFER;
                        src <= pick;
                        irq_vector <= pick_vec;
                        irq_level <= take_hi;
                        irq_pending <= 1'b1;
                    end
                end
                OFFER: begin
                    if (irq_ack) begin
                        state <= ARB;
                        irq_pending <= 1'b0;
                    end
                end
                default: state <= ARB;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_vector_range: assert property ( // [RULE1]
        irq_pending |-> irq_vector[2:0] == 3'h3 && irq_vector <= VEC_LAST)
        else $error("vector out of map");
    chk_global_gate: assert property ( // [RULE2]
        !interrupt_enable_mask[B_GLOBAL] && state == ARB |=> !irq_pending)
        else $error("offer with global enable clear");
    chk_no_nest_high: assert property ( // [RULE19]
        in_hi && state == ARB |=> !irq_pending)
        else $error("nested over high level");
    chk_ext3_edge: assert property ( // [RULE7]
        ext_type[3] && ext_prev[3] && !ext_pin[3] |=> extra_external_irq_control[B_X3_FLAG])
        else $error("ext3 edge flag not set");
    chk_t0_ack_clear: assert property ( // [RULE10]
        ack && src == SRC_T0 && !t0_set && !wr_tctl |=> !timer_run_and_flag_control[B_T0_OVF])
        else $error("timer0 flag not cleared on vector");
    chk_run_stop: assert property ( // [RULE11]
        !run0_bit && !wr_tl0 |=> timer0_low_byte == $past(timer0_low_byte))
        else $error("timer0 counts while stopped");
    chk_gate_hold: assert property ( // [RULE12]
        tm1.gate && !ext1_pin && !wr_tl1 |=> $stable(timer1_low_byte))
        else $error("gated timer1 counts with pin low");
    chk_reload_byte: assert property ( // [RULE15]
        cnt0 && tm0.mode == MODE_RELOAD && timer0_low_byte == 8'hFF && !wr_tl0
        |=> timer0_low_byte == $past(timer0_high_byte))
        else $error("reload missed");
    chk_t1_hold: assert property ( // [RULE17]
        tm1.mode == MODE_SPLIT && !wr_tl1 && !wr_th1
        |=> $stable({timer1_high_byte, timer1_low_byte}))
        else $error("timer1 moves in mode 11");
    chk_wait_pulse: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low twice");
    chk_ext0_edge: assert property ( // [RULE8]
        ext_type[0] && ext_prev[0] && !ext_pin[0] |=> timer_run_and_flag_control[B_X0_FLAG])
        else $error("ext0 edge flag not set");
    chk_carry_13: assert property ( // [RULE14]
        cnt0 && tm0.mode == MODE_13 && timer0_low_byte[4:0] == 5'h1F && !wr_th0
        |=> timer0_high_byte == $past(timer0_high_byte) + 8'h01)
        else $error("13-bit carry missed");
    chk_split_flag: assert property ( // [RULE16]
        th0_cnt && timer0_high_byte == 8'hFF |=> timer_run_and_flag_control[B_T1_OVF])
        else $error("split high byte overflow lost");
    chk_preempt_high: assert property ( // [RULE19]
        state == ARB && !in_hi && (|hi) |=> irq_pending && irq_level)
        else $error("high request not offered");
endmodule : irq_timer_ctl

//--- verif/core_model.sv
// Behavioural processor core that takes vectors and returns from routines
module core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic irq_pending,
    input wire logic [7:0] irq_vector,
    input wire logic irq_level,
    input wire logic [7:0] svc_len,
    input wire logic ack_slow,
    output logic irq_ack = 1'b0,
    output logic irq_return = 1'b0,
    output logic [7:0] last_vec,
    output logic last_lvl,
    output logic [7:0] n_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] depth;
    logic [7:0] left;
    logic [1:0] wait_c;
    // Acks only while an offer stands; nested routines return innermost first
    always @(posedge clk) begin
        irq_ack <= 1'b0;
        irq_return <= 1'b0;
        if (!rst_n) begin
            depth <= 3'h0;
            left <= 8'h00;
            wait_c <= 2'h0;
            n_ack <= 8'h00;
            last_vec <= 8'h00;
            last_lvl <= 1'b0;
        end else if (irq_pending && !irq_ack) begin
            if (wait_c >= {ack_slow, ack_slow}) begin
                irq_ack <= 1'b1;
                last_vec <= irq_vector;
                last_lvl <= irq_level;
                n_ack <= n_ack + 8'h01;
                depth <= depth + 3'h1;
                left <= svc_len;
                wait_c <= 2'h0;
            end else begin
                wait_c <= wait_c + 2'h1;
            end
        end else if (depth != 3'h0) begin
            if (left == 8'h00) begin
                irq_return <= 1'b1;
                depth <= depth - 3'h1;
                left <= svc_len;
            end else begin
                left <= left - 8'h01;
            end
        end
    end
endmodule : core_model

//--- verif/irq_timer_ctl_bench.sv
// Self-checking bench for the interrupt and timer control block
module irq_timer_ctl_bench;
    import irq_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic ext0_pin = 1'b1;
    logic ext1_pin = 1'b1;
    logic [3:0] four_bit_port = 4'hF;
    logic t0_pin = 1'b1;
    logic t1_pin = 1'b1;
    logic serial_irq = 1'b0;
    logic timer2_irq = 1'b0;
    logic irq_ack, irq_return, irq_pending, irq_level, last_lvl;
    logic [7:0] irq_vector, last_vec, n_ack;
    logic [7:0] svc_len = 8'h04;
    logic ack_slow = 1'b1;
    int n_mismatch = 0;
    int compares = 0;
    int nexp = 0;
    always #4 clk = ~clk;
    irq_timer_ctl #(.TICK_DIV(2)) i_dut (.clk, .rst_n, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .ext0_pin, .ext1_pin, .four_bit_port, .t0_pin,
        .t1_pin, .serial_irq, .timer2_irq, .irq_ack, .irq_return, .irq_pending, .irq_vector,
        .irq_level);
    core_model i_core (.clk, .rst_n, .irq_pending, .irq_vector, .irq_level, .svc_len,
        .ack_slow, .irq_ack, .irq_return, .last_vec, .last_lvl, .n_ack);
    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        address <= {idx, 2'b00};
        writedata <= {24'h00_0000, d};
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk_vec(input logic [7:0] v, input logic l);
        compares++;
        if ({last_vec, last_lvl} !== {v, l}) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: vector %h/%b expected %h/%b", $time, last_vec,
                last_lvl, v, l);
        end
    endtask : chk_vec
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk8(q, exp);
    endtask : rd_chk
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            chk8({7'h00, irq_pending}, 8'h00);
        end
    endtask : quiet
    task automatic wait_ack;
        int i;
        nexp++;
        i = 0;
        while (n_ack !== 8'(nexp) && i < 300) begin
            @(posedge clk);
            i++;
        end
        chk8(n_ack, 8'(nexp));
    endtask : wait_ack
    task automatic pulse_t1(input int n);
        repeat (n) begin
            t1_pin <= 1'b0;
            repeat (3) @(posedge clk);
            t1_pin <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask : pulse_t1
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs;
        logic [7:0] idx [5] = '{IDX_TCTL, IDX_TMODE, IDX_ENA, IDX_PRI, IDX_XCTL};
        foreach (idx[i]) rd_chk(idx[i], RST_REG);
        wr(8'h90, 8'hFF);
        rd_chk(8'h90, 8'h00);
        wr(IDX_ENA, 8'hFF);
        rd_chk(IDX_ENA, 8'hBF);
        wr(IDX_PRI, 8'hFF);
        rd_chk(IDX_PRI, 8'h3F);
        wr(IDX_ENA, 8'h00);
        wr(IDX_PRI, 8'h00);
    endtask : test_regs
    task automatic test_order;
        wr(IDX_TCTL, 8'hA5);
        ext0_pin <= 1'b0;
        ext1_pin <= 1'b0;
        wr(IDX_XCTL, 8'h54);
        four_bit_port <= 4'h3;
        serial_irq <= 1'b1;
        timer2_irq <= 1'b1;
        rd_chk(IDX_TCTL, 8'hAF);
        rd_chk(IDX_XCTL, 8'h74);
        wr(IDX_ENA, 8'h3F);
        quiet(10);
        wr(IDX_ENA, 8'hBF);
        for (int i = 0; i < N_SRC; i++) begin
            wait_ack();
            chk_vec(VEC_BASE + 8'(i * 8), 1'b0);
            case (i)
                4: serial_irq <= 1'b0;
                5: timer2_irq <= 1'b0;
                6: four_bit_port[3] <= 1'b1;
                default: ;
            endcase
        end
        rd_chk(IDX_TCTL, 8'h05);
        rd_chk(IDX_XCTL, 8'h54);
        repeat (20) @(posedge clk);
    endtask : test_order
    task automatic test_preempt;
        svc_len <= 8'd40;
        ack_slow <= 1'b0;
        wr(IDX_XCTL, 8'h0C);
        wr(IDX_ENA, 8'hB0);
        serial_irq <= 1'b1;
        wait_ack();
        chk_vec(8'h23, 1'b0);
        serial_irq <= 1'b0;
        four_bit_port[3] <= 1'b0;
        wait_ack();
        chk_vec(8'h33, 1'b1);
        four_bit_port[3] <= 1'b1;
        timer2_irq <= 1'b1;
        quiet(45);
        wait_ack();
        chk_vec(VEC_BASE + 8'h28, 1'b0);
        timer2_irq <= 1'b0;
        repeat (60) @(posedge clk);
    endtask : test_preempt
    task automatic test_timers;
        logic [7:0] q;
        ext1_pin <= 1'b1;
        wr(IDX_ENA, 8'h00);
        wr(IDX_TMODE, 8'hD2);
        wr(IDX_TH0, 8'hF0);
        wr(IDX_TL0, 8'hFE);
        wr(IDX_TCTL, 8'h10);
        repeat (20) @(posedge clk);
        rd_chk(IDX_TCTL, 8'h30);
        bus(1'b0, IDX_TL0, 8'h00, q);
        chk8(q & 8'hF0, 8'hF0);
        rd_chk(IDX_TH0, 8'hF0);
        wr(IDX_TCTL, 8'h00);
        wr(IDX_TL0, 8'h55);
        repeat (20) @(posedge clk);
        rd_chk(IDX_TL0, 8'h55);
        wr(IDX_TL1, 8'h00);
        wr(IDX_TCTL, 8'h40);
        pulse_t1(3);
        rd_chk(IDX_TL1, 8'h03);
        ext1_pin <= 1'b0;
        pulse_t1(2);
        rd_chk(IDX_TL1, 8'h03);
        ext1_pin <= 1'b1;
        wr(IDX_TMODE, 8'hF2);
        pulse_t1(2);
        rd_chk(IDX_TL1, 8'h03);
    endtask : test_timers
    // A few ticks only: 13-bit carries into the high byte, 16-bit would not
    task automatic test_modes;
        wr(IDX_TMODE, 8'h00);
        wr(IDX_TH0, 8'h00);
        wr(IDX_TL0, 8'h1F);
        wr(IDX_TCTL, 8'h10);
        repeat (4) @(posedge clk);
        wr(IDX_TCTL, 8'h00);
        rd_chk(IDX_TH0, 8'h01);
        wr(IDX_TMODE, 8'h03);
        wr(IDX_TH0, 8'hFF);
        wr(IDX_TCTL, 8'h40);
        repeat (4) @(posedge clk);
        rd_chk(IDX_TCTL, 8'hC0);
    endtask : test_modes
    // ----------------------------------------
    // Verdict, sequence and watchdog
    // ----------------------------------------
    task automatic summarize;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_regs();
        test_order();
        test_preempt();
        test_timers();
        test_modes();
        summarize();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule : irq_timer_ctl_bench
